// ===== pkg/sinc_rate_pkg.sv
// constants for the sinc filter conversion pacing block
package sinc_rate_pkg;
	localparam int DIV_W = 10;
	localparam logic [9:0] DIV_MIN = 10'h001;
	localparam logic [9:0] DIV_MAX = 10'h3ff;
	localparam logic [9:0] DIV_RESET = 10'h060;
	localparam int MODE_DIV_LSB = 0;
	localparam int MODE_ZERO_LAT_BIT = 11;
	localparam logic [2:0] ORDER_SINC3 = 3'h3;
	localparam logic [2:0] ORDER_SINC4 = 3'h4;
	localparam logic [10:0] DECIM_BASE = 11'h400;
	localparam logic [1:0] CHOP_SETTLE_PERIODS = 2'h2;
	localparam int CNT_W = 24;
	localparam int CLK_MHZ = 50;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_RUN
	} pace_state_e;
endpackage : sinc_rate_pkg

// ===== verilog/period_counter.sv
// free counter that pulses when a programmed period has elapsed
`timescale 1ns/100ps
module period_counter
	import sinc_rate_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic restart,
	input wire logic run,
	input wire logic [CNT_W-1:0] period,
	output logic tick
);
	logic [CNT_W-1:0] count_reg;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			count_reg <= '0;
		else if (restart || !run)
			count_reg <= '0;
		else if (count_reg + 24'h000001 >= period)
			count_reg <= '0;
		else
			count_reg <= count_reg + 24'h000001;
	end

	assign tick = run && !restart && (count_reg + 24'h000001 >= period);
endmodule : period_counter

// ===== verilog/sinc_rate_timing.sv
// conversion pacing and settling control of the decimation filter
`timescale 1ns/100ps
// Functional notes
// - chop sinc3 output word every 3*1024*divider master clocks
// - divider is ten bits, legal 1..1023; zero treated as 1
// - chop settling lasts two output word periods
// - channel change resets modulator and filter before new conversion
// - first result after full settling, then one per output period
// - input step never restarts the filter; results keep coming
// - step reflected no sooner than second result after the step
// - step during conversion: third result is first settled one
// - dual mains notch bit alters response only, not rate
// - multichannel throughput is rate over 4, 3 or 2
// - zero latency: every result settled, rate equals throughput
// - chop alternates polarity and averages consecutive conversions
// - zero latency bit 11 gives full settling to every conversion
module sinc_rate_timing
	import sinc_rate_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic [11:0] mode_word,
	input wire logic chop_enable,
	input wire logic sinc4_select,
	input wire logic dual_mains_notch_select,
	input wire logic [1:0] channel_select,
	input wire logic multi_channel,
	input wire logic input_step,
	output logic modulator_reset,
	output logic filter_reset,
	output logic chop_polarity,
	output logic average_enable,
	output logic result_ready,
	output logic result_settled,
	output logic notch_mode,
	output logic [1:0] result_channel,
	output logic [1:0] results_since_step,
	output logic divider_illegal,
	output logic high_rate_hint
);
	// ----------------------------------------------------------------
	// rate decode
	// ----------------------------------------------------------------
	logic [9:0] divider;
	logic zero_latency;
	logic [2:0] order;
	logic [CNT_W-1:0] word_period;
	logic [CNT_W-1:0] conv_period;

	function automatic logic [CNT_W-1:0] cycles_of(
		input logic [2:0] ord,
		input logic [9:0] div
	);
		logic [CNT_W-1:0] p;
		p = CNT_W'(ord) * CNT_W'(DECIM_BASE) * CNT_W'(div);
		return p;
	endfunction : cycles_of

	assign divider = (mode_word[MODE_DIV_LSB +: DIV_W] == 10'h000) ?
		DIV_MIN : mode_word[MODE_DIV_LSB +: DIV_W];
	assign divider_illegal = (mode_word[MODE_DIV_LSB +: DIV_W] == 10'h000);
	assign zero_latency = mode_word[MODE_ZERO_LAT_BIT];
	assign order = sinc4_select ? ORDER_SINC4 : ORDER_SINC3;
	// notch bit never enters the period: rate stays the same
	assign word_period = cycles_of(order, divider);
	// settled conversions needed before a fresh word: chop 2, else order
	assign conv_period = word_period;
	assign notch_mode = dual_mains_notch_select;
	// sinc4 is advised above 1 khz: divider of 16 or less at 50 mhz
	assign high_rate_hint = !sinc4_select && (divider < 10'h011);

	// ----------------------------------------------------------------
	// channel change detection
	// ----------------------------------------------------------------
	logic [1:0] chan_reg;
	logic chan_change;
	logic restart;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			chan_reg <= 2'h0;
		else
			chan_reg <= channel_select;
	end

	assign chan_change = enable && (channel_select != chan_reg);
	// step is deliberately not part of restart: the filter runs on
	assign restart = chan_change || !enable;

	// ----------------------------------------------------------------
	// pacing state
	// ----------------------------------------------------------------
	pace_state_e state_reg;
	logic [2:0] settle_cnt_reg;
	logic [2:0] settle_need;
	logic tick;
	logic full_settle;

	period_counter u_period (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.restart(restart),
		.run(enable),
		.period(conv_period),
		.tick(tick)
	);

	// zero latency and sequencing both demand a full settle every word
	assign full_settle = zero_latency || multi_channel;
	assign settle_need = chop_enable ? {1'b0, CHOP_SETTLE_PERIODS} :
		order;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			state_reg <= ST_IDLE;
		else if (!enable)
			state_reg <= ST_IDLE;
		else if (chan_change)
			state_reg <= ST_SETTLE;
		else
		begin
			case (state_reg)
				ST_IDLE:
					state_reg <= ST_SETTLE;
				ST_SETTLE:
					if (tick && settle_cnt_reg + 3'h1 >= settle_need
						&& !full_settle)
						state_reg <= ST_RUN;
				ST_RUN:
					if (full_settle)
						state_reg <= ST_SETTLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			settle_cnt_reg <= 3'h0;
		else if (restart || state_reg != ST_SETTLE)
			settle_cnt_reg <= 3'h0;
		else if (tick)
		begin
			if (settle_cnt_reg + 3'h1 >= settle_need)
				settle_cnt_reg <= 3'h0;
			else
				settle_cnt_reg <= settle_cnt_reg + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// reset pulses and results
	// ----------------------------------------------------------------
	logic word_done;

	assign word_done = tick && ((state_reg == ST_RUN) ||
		(state_reg == ST_SETTLE && settle_cnt_reg + 3'h1 >= settle_need));

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			modulator_reset <= 1'b0;
			filter_reset <= 1'b0;
		end
		else
		begin
			modulator_reset <= chan_change;
			filter_reset <= chan_change;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			result_ready <= 1'b0;
			result_channel <= 2'h0;
		end
		else
		begin
			result_ready <= word_done;
			if (word_done)
				result_channel <= chan_reg;
		end
	end

	// chop polarity flips on every period tick, settling ones included; outputs averaged
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			chop_polarity <= 1'b0;
		else if (restart)
			chop_polarity <= 1'b0;
		else if (chop_enable && tick)
			chop_polarity <= !chop_polarity;
	end

	assign average_enable = chop_enable;

	// ----------------------------------------------------------------
	// step tracking: count results after a step, flag settled
	// ----------------------------------------------------------------
	logic step_sync1_reg;
	logic step_sync2_reg;
	logic step_prev_reg;
	logic step_evt;
	logic step_async_reg;
	logic step_pending_reg;
	logic [1:0] step_need;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			step_sync1_reg <= 1'b0;
			step_sync2_reg <= 1'b0;
			step_prev_reg <= 1'b0;
		end
		else
		begin
			step_sync1_reg <= input_step;
			step_sync2_reg <= step_sync1_reg;
			step_prev_reg <= step_sync2_reg;
		end
	end

	assign step_evt = step_sync2_reg && !step_prev_reg;
	// step aligned to a word boundary needs 2, mid conversion needs 3
	assign step_need = step_async_reg ? 2'h3 : 2'h2;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			step_pending_reg <= 1'b0;
			step_async_reg <= 1'b0;
			results_since_step <= 2'h0;
		end
		else if (restart)
		begin
			step_pending_reg <= 1'b0;
			step_async_reg <= 1'b0;
			results_since_step <= 2'h0;
		end
		else if (step_evt)
		begin
			// new step wins over any count in progress
			step_pending_reg <= 1'b1;
			step_async_reg <= !word_done;
			results_since_step <= 2'h0;
		end
		else if (word_done && step_pending_reg)
		begin
			results_since_step <= results_since_step + 2'h1;
			if (results_since_step + 2'h1 >= step_need)
				step_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			result_settled <= 1'b0;
		else if (word_done)
			result_settled <= full_settle || !step_pending_reg
				|| (results_since_step + 2'h1 >= step_need);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_reset_on_change;
		@(posedge clk_sys) disable iff (sys_rst)
		chan_change |=> modulator_reset && filter_reset;
	endproperty
	a_reset_on_change: assert property (p_reset_on_change)
		else $error("channel change did not reset filter");

	property p_no_result_after_change;
		@(posedge clk_sys) disable iff (sys_rst)
		chan_change |=> !result_ready [*2];
	endproperty
	a_no_result_after_change: assert property (p_no_result_after_change)
		else $error("result too soon after channel change");

	property p_step_no_restart;
		@(posedge clk_sys) disable iff (sys_rst)
		(step_evt && !restart && state_reg == ST_RUN && !full_settle)
			|=> state_reg == ST_RUN;
	endproperty
	a_step_no_restart: assert property (p_step_no_restart)
		else $error("input step restarted the filter");

	property p_zero_lat_settled;
		@(posedge clk_sys) disable iff (sys_rst)
		(word_done && zero_latency) |=> result_settled;
	endproperty
	a_zero_lat_settled: assert property (p_zero_lat_settled)
		else $error("zero latency result not settled");

	property p_ready_pulse;
		@(posedge clk_sys) disable iff (sys_rst)
		result_ready && conv_period > 24'h000002 |=> !result_ready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("result ready longer than one cycle");

	property p_chop_flip;
		@(posedge clk_sys) disable iff (sys_rst)
		(chop_enable && tick && !restart) |=>
			chop_polarity != $past(chop_polarity);
	endproperty
	a_chop_flip: assert property (p_chop_flip)
		else $error("chop polarity did not alternate");

	property p_step_first_unsettled;
		@(posedge clk_sys) disable iff (sys_rst)
		(word_done && step_pending_reg && results_since_step == 2'h0
			&& !full_settle && !step_evt) |=> !result_settled;
	endproperty
	a_step_first_unsettled: assert property (p_step_first_unsettled)
		else $error("first result after step marked settled");

	property p_period_value;
		@(posedge clk_sys) disable iff (sys_rst)
		!sinc4_select && !divider_illegal |-> word_period ==
			CNT_W'(mode_word[9:0]) * 24'h000c00;
	endproperty
	a_period_value: assert property (p_period_value)
		else $error("output word period wrong");

	c_change: cover property (@(posedge clk_sys) chan_change);
	c_result: cover property (@(posedge clk_sys) result_ready);
	c_step: cover property (@(posedge clk_sys) step_evt && step_pending_reg);
endmodule : sinc_rate_timing

// ===== test/host_reader.sv
// host side model that collects result timing
`timescale 1ns/100ps
module host_reader
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic result_ready,
	output int gap,
	output int seen
);
	int run_cnt;

	// host only counts results and the clocks between them; it never stalls the device
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			run_cnt <= 0;
			gap <= 0;
			seen <= 0;
		end
		else if (result_ready === 1'b1)
		begin
			gap <= run_cnt + 1;
			run_cnt <= 0;
			seen <= seen + 1;
		end
		else
			run_cnt <= run_cnt + 1;
	end
endmodule : host_reader

// ===== test/sinc_filter_rate_timing_test.sv
// self-checking bench for the conversion pacing block
`timescale 1ns/100ps
module sinc_filter_rate_timing_test;
	import sinc_rate_pkg::*;
	localparam int P = 3072;
	logic clk_sys = 0, sys_rst = 1, enable = 0, chop_enable = 1;
	logic sinc4_select = 0, notch = 0, multi_channel = 0, input_step = 0;
	logic [11:0] mode_word = 12'h000;
	logic [1:0] channel_select = 2'h0, result_channel, since_step;
	logic mod_rst, fil_rst, chop_polarity, average_enable, result_ready;
	logic result_settled, notch_mode, divider_illegal, high_rate_hint;
	logic pol;
	int n_fail = 0, tests_run = 0, n, gap, seen, i;
	int saw_m, saw_f;

	always #10 clk_sys = ~clk_sys;

	sinc_rate_timing dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.enable(enable), .mode_word(mode_word), .chop_enable(chop_enable),
		.sinc4_select(sinc4_select), .dual_mains_notch_select(notch),
		.channel_select(channel_select), .multi_channel(multi_channel),
		.input_step(input_step), .modulator_reset(mod_rst),
		.filter_reset(fil_rst), .chop_polarity(chop_polarity),
		.average_enable(average_enable), .result_ready(result_ready),
		.result_settled(result_settled), .notch_mode(notch_mode),
		.result_channel(result_channel), .results_since_step(since_step),
		.divider_illegal(divider_illegal), .high_rate_hint(high_rate_hint));

	host_reader host (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.result_ready(result_ready), .gap(gap), .seen(seen));

	task cmp_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_bit

	task cmp_int(input string what, input int exp, input int got);
		tests_run++;
		if (got != exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask : cmp_int

	task wait_rdy;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		while (result_ready !== 1'b1 && n < 20000);
		cmp_bit("ready", 1'b1, result_ready);
		// host updates its gap on the edge that sees ready
		@(posedge clk_sys);
		#2;
	endtask : wait_rdy

	task conclude;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (90000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end

	initial
	begin
		repeat (16) @(posedge clk_sys);
		#2;
		cmp_bit("ready_in_reset", 1'b0, result_ready);
		cmp_bit("div_zero", 1'b1, divider_illegal);
		cmp_bit("avg", 1'b1, average_enable);
		mode_word = 12'h001;
		notch = 1'b1;
		#1;
		cmp_bit("div_one", 1'b0, divider_illegal);
		cmp_bit("notch", 1'b1, notch_mode);
		cmp_bit("hint", 1'b1, high_rate_hint);
		sys_rst = 1'b0;
		notch = 1'b0;
		$display("test reset done");
		@(posedge clk_sys);
		#2;
		enable = 1'b1;
		wait_rdy();
		cmp_bit("first_settle", 1'b1, n >= 2 * P && n <= 2 * P + 3);
		pol = chop_polarity;
		wait_rdy();
		cmp_int("gap_chop", P, gap);
		cmp_bit("polarity", ~pol, chop_polarity);
		$display("test rate done");
		repeat (P / 2) @(posedge clk_sys);
		#2;
		input_step = 1'b1;
		repeat (3) @(posedge clk_sys);
		#2;
		input_step = 1'b0;
		wait_rdy();
		cmp_bit("step_first", 1'b0, result_settled);
		for (i = 0; i < 2; i++)
		begin
			wait_rdy();
			cmp_int("step_gap", P, gap);
		end
		cmp_bit("step_third", 1'b1, result_settled);
		cmp_bit("since_step", 1'b1, since_step === 2'h3);
		$display("test step done");
		notch = 1'b1;
		wait_rdy();
		wait_rdy();
		cmp_int("notch_gap", P, gap);
		$display("test notch done");
		@(posedge clk_sys);
		#2;
		channel_select = 2'h2;
		saw_m = 0;
		saw_f = 0;
		repeat (3)
		begin
			@(posedge clk_sys);
			#1;
			saw_m += int'(mod_rst === 1'b1);
			saw_f += int'(fil_rst === 1'b1);
		end
		cmp_int("mod_reset", 1, saw_m);
		cmp_int("fil_reset", 1, saw_f);
		wait_rdy();
		cmp_bit("chg_settle", 1'b1, n >= 2 * P - 3 && n <= 2 * P + 1);
		cmp_bit("chan", 1'b1, result_channel === 2'h2);
		wait_rdy();
		cmp_int("chg_gap", P, gap);
		$display("test channel done");
		multi_channel = 1'b1;
		wait_rdy();
		wait_rdy();
		cmp_int("multi_gap", 2 * P, gap);
		$display("test multi done");
		multi_channel = 1'b0;
		mode_word = 12'h801;
		wait_rdy();
		wait_rdy();
		cmp_int("zl_gap", 2 * P, gap);
		cmp_bit("zl_settled", 1'b1, result_settled);
		$display("test zero latency done");
		mode_word = 12'h001;
		multi_channel = 1'b1;
		chop_enable = 1'b0;
		#1;
		cmp_bit("avg_off", 1'b0, average_enable);
		wait_rdy();
		wait_rdy();
		cmp_int("nochop_gap", 3 * P, gap);
		$display("test no chop done");
		conclude();
	end
endmodule : sinc_filter_rate_timing_test
